// >>> rtl/ucr_channel_regs.sv
// register map and address decode of one channel of a quad uart
`timescale 1ns/1ps
`include "ucr_cfg.svh"
module ucr_channel_regs import ucr_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic chip_select_n,
	input wire logic fifo_summary_select_n,
	input wire logic [2:0] addr,
	input wire logic read_n,
	input wire logic write_n,
	input wire logic [7:0] wr_data,
	input wire ucr_status_t status,
	output logic [7:0] rd_data,
	output logic tx_load,
	output logic [7:0] tx_data,
	output logic rx_pop,
	output logic lstat_read,
	output logic mstat_read,
	output logic fctl_write,
	output logic [7:0] divisor_low_byte,
	output logic [7:0] divisor_high_byte,
	output logic [7:0] line_control,
	output logic [7:0] modem_control_eff,
	output logic [7:0] interrupt_enable_eff,
	output logic [7:0] fifo_control_eff,
	output logic [7:0] enhanced_function,
	output logic [31:0] flow_chars,
	output logic interrupt_n
);
	// ==========================================================
	// pin synchronisers
	// ==========================================================
	logic [4:0] ctl_meta;
	logic [4:0] ctl_sync;
	logic [2:0] addr_meta;
	logic [2:0] addr_sync;
	logic [7:0] wd_meta;
	logic [7:0] wd_sync;
	logic rd_prev;
	logic wr_prev;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctl_meta <= 5'h1F;
			ctl_sync <= 5'h1F;
			addr_meta <= 3'h0;
			addr_sync <= 3'h0;
			wd_meta <= 8'h00;
			wd_sync <= 8'h00;
			rd_prev <= 1'b1;
			wr_prev <= 1'b1;
		end else begin
			ctl_meta <= {chip_select_n, fifo_summary_select_n, read_n, write_n, 1'b1};
			ctl_sync <= ctl_meta;
			addr_meta <= addr;
			addr_sync <= addr_meta;
			wd_meta <= wr_data;
			wd_sync <= wd_meta;
			rd_prev <= ctl_sync[2];
			wr_prev <= ctl_sync[1];
		end
	end

	logic cs_n_s;
	logic fsel_n_s;
	logic rd_fall;
	logic wr_rise;
	assign cs_n_s = ctl_sync[4];
	assign fsel_n_s = ctl_sync[3];
	assign rd_fall = rd_prev && !ctl_sync[2];
	// write data is taken at the trailing edge of the strobe, when it is stable
	assign wr_rise = !wr_prev && ctl_sync[1];

	// ==========================================================
	// state
	// ==========================================================
	ucr_state_t st;
	ucr_state_t next_st;

	logic div_mode;
	logic enh_mode;
	logic enh_en;
	logic acc;
	assign enh_mode = (st.line_control == `UCR_ENH_KEY);
	assign div_mode = st.line_control[`UCR_LCTL_DIV_BIT] && !enh_mode;
	assign enh_en = st.enhanced_function[`UCR_ENHFN_EN_BIT];
	assign acc = !cs_n_s;

	// ==========================================================
	// interrupt status priority
	// ==========================================================
	logic [7:0] istat;
	logic [7:0] ien_eff;
	logic [7:0] mctl_eff;
	logic [7:0] fctl_eff;
	assign ien_eff = enh_en ? st.interrupt_enable : (st.interrupt_enable & ~`UCR_IEN_GATE_MASK);
	assign mctl_eff = enh_en ? st.modem_control : (st.modem_control & ~`UCR_MCTL_GATE_MASK);
	assign fctl_eff = enh_en ? st.fifo_control : (st.fifo_control & ~`UCR_FCTL_GATE_MASK);

	always_comb begin
		istat = `UCR_ISTAT_NONE;
		if (ien_eff[`UCR_IEN_LS_BIT] && (|status.line_status[4:1])) begin
			istat = `UCR_ISTAT_LINE;
		end else if (ien_eff[`UCR_IEN_RX_BIT] && status.line_status[0]) begin
			istat = `UCR_ISTAT_RXRDY;
		end else if (ien_eff[`UCR_IEN_TX_BIT] && status.line_status[5]) begin
			istat = `UCR_ISTAT_TXRDY;
		end else if (ien_eff[`UCR_IEN_MS_BIT] && (|status.modem_status[3:0])) begin
			istat = `UCR_ISTAT_MODEM;
		end
		istat[7:6] = {2{st.fifo_control[0]}};
		if (!enh_en) begin
			istat = istat & ~`UCR_ISTAT_GATE_MASK;
		end
	end

	// ==========================================================
	// register decode
	// ==========================================================
	always_comb begin
		next_st = st;
		next_st.tx_load = 1'b0;
		next_st.rx_pop = 1'b0;
		next_st.lstat_read = 1'b0;
		next_st.mstat_read = 1'b0;
		next_st.fctl_write = 1'b0;
		next_st.irq_n = !(istat[0] == 1'b0 && mctl_eff[`UCR_MCTL_IRQ_OE_BIT]);
		if (!fsel_n_s && rd_fall) begin
			next_st.rd_data = {status.rx_ready, status.tx_ready};
		end else if (acc && rd_fall) begin
			unique case (addr_sync)
				`UCR_ADDR_HOLD: begin
					if (div_mode) begin
						next_st.rd_data = st.divisor_low_byte;
					end else begin
						next_st.rd_data = status.receive_holding;
						next_st.rx_pop = 1'b1;
					end
				end
				`UCR_ADDR_IEN: next_st.rd_data = div_mode ? st.divisor_high_byte : ien_eff;
				`UCR_ADDR_ISTAT: next_st.rd_data = enh_mode ? st.enhanced_function : istat;
				`UCR_ADDR_LCTL: next_st.rd_data = st.line_control;
				`UCR_ADDR_MCTL: next_st.rd_data = enh_mode ? st.resume_char_first : mctl_eff;
				`UCR_ADDR_LSTAT: begin
					next_st.rd_data = enh_mode ? st.resume_char_second : status.line_status;
					next_st.lstat_read = !enh_mode;
				end
				`UCR_ADDR_MSTAT: begin
					next_st.rd_data = enh_mode ? st.stop_char_first : status.modem_status;
					next_st.mstat_read = !enh_mode;
				end
				`UCR_ADDR_SCR: next_st.rd_data = enh_mode ? st.stop_char_second : st.scratch_byte;
			endcase
		end
		if (acc && wr_rise) begin
			unique case (addr_sync)
				`UCR_ADDR_HOLD: begin
					if (div_mode) begin
						next_st.divisor_low_byte = wd_sync;
					end else begin
						next_st.tx_data = wd_sync;
						next_st.tx_load = 1'b1;
					end
				end
				`UCR_ADDR_IEN: begin
					if (div_mode) begin
						next_st.divisor_high_byte = wd_sync;
					end else begin
						next_st.interrupt_enable = wd_sync;
					end
				end
				`UCR_ADDR_ISTAT: begin
					if (enh_mode) begin
						next_st.enhanced_function = wd_sync;
					end else begin
						next_st.fifo_control = wd_sync;
						next_st.fctl_write = 1'b1;
					end
				end
				`UCR_ADDR_LCTL: next_st.line_control = wd_sync;
				`UCR_ADDR_MCTL: begin
					if (enh_mode) begin
						next_st.resume_char_first = wd_sync;
					end else begin
						next_st.modem_control = wd_sync;
					end
				end
				`UCR_ADDR_LSTAT: begin
					if (enh_mode) begin
						next_st.resume_char_second = wd_sync;
					end
					// line status is never written
				end
				`UCR_ADDR_MSTAT: begin
					if (enh_mode) begin
						next_st.stop_char_first = wd_sync;
					end
					// modem status writes are dropped
				end
				`UCR_ADDR_SCR: begin
					if (enh_mode) begin
						next_st.stop_char_second = wd_sync;
					end else begin
						next_st.scratch_byte = wd_sync;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
			st.irq_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// outputs
	// ==========================================================
	logic [7:0] mctl_q;
	logic [7:0] ien_q;
	logic [7:0] fctl_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mctl_q <= `UCR_RESET_BYTE;
			ien_q <= `UCR_RESET_BYTE;
			fctl_q <= `UCR_RESET_BYTE;
		end else begin
			mctl_q <= mctl_eff;
			ien_q <= ien_eff;
			fctl_q <= fctl_eff;
		end
	end

	assign rd_data = st.rd_data;
	assign tx_load = st.tx_load;
	assign tx_data = st.tx_data;
	assign rx_pop = st.rx_pop;
	assign lstat_read = st.lstat_read;
	assign mstat_read = st.mstat_read;
	assign fctl_write = st.fctl_write;
	assign divisor_low_byte = st.divisor_low_byte;
	assign divisor_high_byte = st.divisor_high_byte;
	assign line_control = st.line_control;
	assign modem_control_eff = mctl_q;
	assign interrupt_enable_eff = ien_q;
	assign fifo_control_eff = fctl_q;
	assign enhanced_function = st.enhanced_function;
	assign flow_chars = {st.stop_char_second, st.stop_char_first, st.resume_char_second, st.resume_char_first};
	assign interrupt_n = st.irq_n;
endmodule : ucr_channel_regs

// >>> rtl/ucr_cfg.svh
// register offsets, field positions and reset values of one uart channel's register map
`ifndef UCR_CFG_SVH
`define UCR_CFG_SVH
`define UCR_ADDR_HOLD 3'h0
`define UCR_ADDR_IEN 3'h1
`define UCR_ADDR_ISTAT 3'h2
`define UCR_ADDR_LCTL 3'h3
`define UCR_ADDR_MCTL 3'h4
`define UCR_ADDR_LSTAT 3'h5
`define UCR_ADDR_MSTAT 3'h6
`define UCR_ADDR_SCR 3'h7
`define UCR_ENH_KEY 8'hBF
`define UCR_LCTL_DIV_BIT 7
`define UCR_ENHFN_EN_BIT 4
`define UCR_IEN_GATE_MASK 8'hF0
`define UCR_MCTL_GATE_MASK 8'hE0
`define UCR_FCTL_GATE_MASK 8'h30
`define UCR_ISTAT_GATE_MASK 8'h30
`define UCR_RESET_BYTE 8'h00
`define UCR_ISTAT_NONE 8'h01
`define UCR_ISTAT_LINE 8'h06
`define UCR_ISTAT_RXRDY 8'h04
`define UCR_ISTAT_TXRDY 8'h02
`define UCR_ISTAT_MODEM 8'h00
`define UCR_IEN_RX_BIT 0
`define UCR_IEN_TX_BIT 1
`define UCR_IEN_LS_BIT 2
`define UCR_IEN_MS_BIT 3
`define UCR_MCTL_IRQ_OE_BIT 3
`endif

// >>> rtl/ucr_pkg.sv
// types shared by the uart channel register map
package ucr_pkg;
	typedef struct packed {
		logic [7:0] divisor_low_byte;
		logic [7:0] divisor_high_byte;
		logic [7:0] interrupt_enable;
		logic [7:0] fifo_control;
		logic [7:0] line_control;
		logic [7:0] modem_control;
		logic [7:0] scratch_byte;
		logic [7:0] enhanced_function;
		logic [7:0] resume_char_first;
		logic [7:0] resume_char_second;
		logic [7:0] stop_char_first;
		logic [7:0] stop_char_second;
		logic [7:0] rd_data;
		logic tx_load;
		logic [7:0] tx_data;
		logic rx_pop;
		logic lstat_read;
		logic mstat_read;
		logic fctl_write;
		logic irq_n;
	} ucr_state_t;

	typedef struct packed {
		logic [7:0] line_status;
		logic [7:0] modem_status;
		logic [7:0] receive_holding;
		logic [3:0] rx_ready;
		logic [3:0] tx_ready;
	} ucr_status_t;
endpackage : ucr_pkg

// >>> verification/ucr_regs_sva.sv
// assertion checker for the uart channel register map
`timescale 1ns/1ps
module ucr_regs_sva import ucr_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic chip_select_n,
	input wire logic write_n,
	input wire logic tx_load,
	input wire logic rx_pop,
	input wire logic lstat_read,
	input wire logic mstat_read,
	input wire logic fctl_write,
	input wire logic [7:0] divisor_low_byte,
	input wire logic [7:0] divisor_high_byte,
	input wire logic [7:0] line_control,
	input wire logic [7:0] modem_control_eff,
	input wire logic [7:0] interrupt_enable_eff,
	input wire logic [7:0] fifo_control_eff,
	input wire logic [7:0] enhanced_function,
	input wire logic [31:0] flow_chars,
	input wire logic interrupt_n
);
	// ========================================
	// configuration that only a taken write may change
	logic [63:0] cfg;
	assign cfg = {divisor_low_byte, divisor_high_byte, line_control, enhanced_function, flow_chars};
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// ========================================
	// properties
	property p_tx_norm; tx_load |-> (!line_control[7] || line_control == 8'hBF) ##1 !tx_load; endproperty
	a_tx_norm: assert property (p_tx_norm) else $error("tx load outside normal bank");
	property p_rx_norm; rx_pop |-> (!line_control[7] || line_control == 8'hBF) ##1 !rx_pop; endproperty
	a_rx_norm: assert property (p_rx_norm) else $error("rx pop outside normal bank");
	property p_fctl; fctl_write |-> !line_control[7]; endproperty
	a_fctl: assert property (p_fctl) else $error("fifo control write in wrong bank");
	property p_lstat; lstat_read |-> !line_control[7]; endproperty
	a_lstat: assert property (p_lstat) else $error("line status read in wrong bank");
	property p_mstat; mstat_read |-> !line_control[7]; endproperty
	a_mstat: assert property (p_mstat) else $error("modem status read in wrong bank");
	property p_gate;
		!enhanced_function[4] && $past(!enhanced_function[4]) |->
			interrupt_enable_eff[7:4] == 4'h0 && modem_control_eff[7:5] == 3'h0;
	endproperty
	a_gate: assert property (p_gate) else $error("gated bits active");
	property p_fgate;
		!enhanced_function[4] && $past(!enhanced_function[4]) |-> fifo_control_eff[5:4] == 2'h0;
	endproperty
	a_fgate: assert property (p_fgate) else $error("gated fifo bits active");
	property p_irq; !modem_control_eff[3] [*3] |-> $past(interrupt_n); endproperty
	a_irq: assert property (p_irq) else $error("interrupt while output disabled");
	property p_idle; write_n [*8] |-> $stable(cfg); endproperty
	a_idle: assert property (p_idle) else $error("config changed without write");
	property p_unsel; chip_select_n [*8] |-> $stable(cfg); endproperty
	a_unsel: assert property (p_unsel) else $error("config changed while unselected");
	c_tx: cover property (tx_load);
	c_rx: cover property (rx_pop);
	c_irq: cover property ($fell(interrupt_n));
endmodule : ucr_regs_sva
bind ucr_channel_regs ucr_regs_sva u_sva (.*);

// >>> verification/ucr_host_model.sv
// host bus model driving one channel's parallel register port
`timescale 1ns/1ps
module ucr_host_model (
	input wire logic clk,
	output logic chip_select_n,
	output logic [2:0] addr,
	output logic read_n,
	output logic write_n,
	output logic [7:0] wr_data,
	input wire logic [7:0] rd_data
);
	logic [7:0] rdv;
	event done;
	initial begin
		chip_select_n = 1'b1;
		addr = 3'h0;
		read_n = 1'b1;
		write_n = 1'b1;
		wr_data = 8'h00;
	end
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask : step
	// data stays past the trailing strobe edge so the synchronisers see it
	task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic sel);
		step(1);
		chip_select_n = !sel;
		addr = a;
		wr_data = d;
		write_n = 1'b0;
		step(4);
		write_n = 1'b1;
		step(4);
		chip_select_n = 1'b1;
		addr = ~a;
		wr_data = ~d;
		step(2);
	endtask : wr
	task automatic rd(input logic [2:0] a);
		step(1);
		chip_select_n = 1'b0;
		addr = a;
		read_n = 1'b0;
		step(6);
		rdv = rd_data;
		->done;
		read_n = 1'b1;
		step(4);
		chip_select_n = 1'b1;
		addr = ~a;
		step(2);
	endtask : rd
endmodule : ucr_host_model

// >>> verification/testbench.sv
// self-checking testbench for the uart channel register map
`timescale 1ns/1ps
module testbench import ucr_pkg::*; ;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic fifo_summary_select_n = 1'b1;
	logic chip_select_n, read_n, write_n, interrupt_n;
	logic [2:0] addr;
	logic [7:0] wr_data, rd_data, tx_data;
	logic [31:0] flow_chars;
	ucr_status_t status;
	logic [7:0] exp_q[$];
	logic [15:0] lfsr = 16'hAE4E;
	int err_total = 0;
	int num_checks = 0;
	always #4 clk = ~clk;
	ucr_host_model host (.clk, .chip_select_n, .addr, .read_n, .write_n, .wr_data, .rd_data);
	ucr_channel_regs DUT (.clk, .resetn, .chip_select_n, .fifo_summary_select_n, .addr, .read_n,
		.write_n, .wr_data, .status, .rd_data, .tx_load(), .tx_data, .rx_pop(), .lstat_read(),
		.mstat_read(), .fctl_write(), .divisor_low_byte(), .divisor_high_byte(), .line_control(),
		.modem_control_eff(), .interrupt_enable_eff(), .fifo_control_eff(), .enhanced_function(),
		.flow_chars, .interrupt_n);
	// ========================================
	// helpers
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction : rnd
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	always @(host.done) chk(host.rdv, exp_q.pop_front());
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.rd(a);
	endtask : rd
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report
	initial begin
		#20000;
		err_total++;
		$display("ERROR %0t: timeout", $time);
		final_report();
	end
	// ========================================
	// main sequence
	initial begin : main
		logic [7:0] v [8];
		status = '{line_status: 8'h20, modem_status: 8'h5A, receive_holding: 8'h00, rx_ready: 4'h9, tx_ready: 4'h6};
		for (int i = 0; i < 8; i++) v[i] = rnd();
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		repeat (3) @(negedge clk);
		rd(3'h3, 8'h00);
		host.wr(3'h3, 8'h83, 1'b1);
		host.wr(3'h0, v[0], 1'b1);
		host.wr(3'h1, v[1], 1'b1);
		rd(3'h0, v[0]);
		rd(3'h1, v[1]);
		rd(3'h3, 8'h83);
		$display("test divisor done");
		host.wr(3'h3, 8'hBF, 1'b1);
		host.wr(3'h2, 8'h10, 1'b1);
		for (int i = 4; i < 8; i++) host.wr(i[2:0], v[i], 1'b1);
		rd(3'h2, 8'h10);
		rd(3'h3, 8'hBF);
		for (int i = 4; i < 8; i++) rd(i[2:0], v[i]);
		for (int i = 4; i < 8; i++) chk(flow_chars[8*(i-4) +: 8], v[i]);
		$display("test enhanced done");
		host.wr(3'h3, 8'h03, 1'b1);
		host.wr(3'h1, 8'hF2, 1'b1);
		host.wr(3'h4, 8'hE8, 1'b1);
		host.wr(3'h7, v[2], 1'b1);
		host.wr(3'h5, 8'hFF, 1'b1);
		host.wr(3'h7, ~v[2], 1'b0);
		host.wr(3'h0, v[5], 1'b1);
		chk(tx_data, v[5]);
		status.receive_holding = v[3];
		chk({7'h00, interrupt_n}, 8'h00);
		rd(3'h1, 8'hF2);
		rd(3'h4, 8'hE8);
		rd(3'h7, v[2]);
		rd(3'h5, 8'h20);
		rd(3'h6, 8'h5A);
		rd(3'h0, v[3]);
		rd(3'h2, 8'h02);
		fifo_summary_select_n = 1'b0;
		rd(3'h3, 8'h96);
		fifo_summary_select_n = 1'b1;
		host.wr(3'h3, 8'hBF, 1'b1);
		host.wr(3'h2, 8'h00, 1'b1);
		host.wr(3'h3, 8'h03, 1'b1);
		rd(3'h1, 8'h02);
		rd(3'h4, 8'h08);
		$display("test normal done");
		final_report();
	end
endmodule : testbench
